/* File: verilog/flash_seq.sv */
// Purpose: Command logic of a serial NOR flash: status, protection,
//   single, quick and dual reads, 4 KiB sector erase.
// Assumes: Chip select stays high at least three core clocks between
//   frames; the serial clock stands still while chip select is high.
// Notes: Frame capture and reads run on the serial clock; write enable, status write and erase execute in
//   the core domain once the synchronised chip select has risen.
// Notes on behaviour
// RL1 - Status write needs write-enable latch set
// RL2 - Status write changes only disable and protect bits
// RL3 - Status write ends exactly after data byte
// RL4 - Status write runs timed, busy, then latch clears
// RL5 - Disable bit with pin low refuses writes
// RL6 - Other pin and bit combos allow writes
// RL7 - Hardware mode entered in either event order
// RL8 - Only pin high leaves hardware mode
// RL9 - Protected area refuses program and erase
// RL10 - Normal read: address rising, data falling
// RL11 - Reads auto-increment and wrap to zero
// RL12 - Quick read adds dummy byte, same edges
// RL13 - Quick and dual reads refused while busy
// RL14 - Dual read: two-bit address, dummy, data
// RL15 - Other commands stay single-bit wide
// RL16 - Sector erase needs latch, clears 4 KiB
// RL17 - Erase ends right after last address bit
// RL18 - Erase runs timed, busy, then latch clears
// RL19 - Protected sector is never erased
// RL20 - Opcode 01 is status write plus byte
// RL21 - Opcode 06 sets write-enable latch
// RL22 - Status read allowed anytime, repeats byte
// RL23 - Data shifted most significant bit first
`timescale 1ns/10ps
module flash_seq
  import flash_seq_pkg::*;
#(
  parameter int unsigned WRITE_CYCLES = STATUS_WRITE_CYCLES,
  parameter int unsigned SECTOR_ERASE_CYCLES = ERASE_CYCLES
)
(
  // Core clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Write-protect pin
  input wire logic wp_n_in,
  // Serial link
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic io0_in,
  output logic io0_out,
  output logic io0_oe_n_out,
  input wire logic io1_in,
  output logic io1_out,
  output logic io1_oe_n_out
);

  // Array; written only in the core domain while busy
  logic [7:0] mem_q [0:MEM_SIZE-1];

  // Serial-clock domain state
  logic fresh_q;
  logic [5:0] cyc_q;
  logic [7:0] op_q;
  logic [7:0] sdat_q;
  logic [ADDR_W-1:0] addr_q;
  logic [MEM_AW-1:0] raddr_q;
  logic [2:0] dcnt_q;
  logic dphase_q;
  logic [7:0] stat_s1_q;
  logic [7:0] stat_s2_q;

  // Core domain state
  logic cs_s1_q;
  logic cs_s2_q;
  logic cs_s3_q;
  logic wp_s1_q;
  logic wp_s2_q;
  core_state_t state_q;
  core_state_t state_d;
  logic [31:0] timer_q;
  logic [31:0] timer_d;
  logic busy_q;
  logic we_latch_q;
  logic we_latch_d;
  logic wr_disable_q;
  logic [3:0] bp_q;
  logic [7:0] wdat_q;
  logic [3:0] esect_q;
  logic [SECT_AW-1:0] ecnt_q;
  logic edone_q;

  // Frame-start flag: armed by chip select, cleared by the first edge
  always_ff @(posedge sclk_in or posedge cs_n_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      fresh_q <= 1'b1;
    else if (cs_n_in)
      fresh_q <= 1'b1;
    else
      fresh_q <= 1'b0;
  end

  // Capture decode on the rising serial clock
  logic [5:0] cyc_n;
  logic [7:0] op_cur;
  logic dual_cur;
  logic addr_single;
  logic addr_dual;
  logic [ADDR_W-1:0] addr_d;
  logic [7:0] sdat_d;
  logic busy_s;
  logic rd_refused;
  logic go_data;
  logic dphase_keep;
  logic dlast;
  logic [2:0] dcnt_d;
  logic [MEM_AW-1:0] raddr_d;

  assign cyc_n = fresh_q ? 6'h01 :
                 (cyc_q == CYC_MAX) ? cyc_q : cyc_q + 6'h01;
  assign op_cur = (cyc_n <= CYC_OPCODE) ? {op_q[6:0], io0_in} : op_q;
  assign dual_cur = op_cur == OP_DUAL_READ;
  assign addr_single = !dual_cur && cyc_n > CYC_OPCODE &&
                       cyc_n <= CYC_ADDR; // RL10
  assign addr_dual = dual_cur && cyc_n > CYC_OPCODE &&
                     cyc_n <= CYC_DUAL_ADDR; // RL14
  assign addr_d = addr_single ? {addr_q[ADDR_W-2:0], io0_in} :
                  addr_dual ? {addr_q[ADDR_W-3:0], io1_in, io0_in} :
                  addr_q;
  assign sdat_d = (cyc_n > CYC_OPCODE && cyc_n <= CYC_STATUS_DATA) ?
                  {sdat_q[6:0], io0_in} : sdat_q; // RL20
  assign busy_s = stat_s2_q[ST_BUSY];
  assign rd_refused = busy_s && (op_cur == OP_FAST_READ ||
                      op_cur == OP_DUAL_READ); // RL13
  // Dummy edges of quick and dual reads are skipped by the start count
  assign go_data = cyc_n == data_start(op_cur) && !rd_refused; // RL12
  assign dphase_keep = dphase_q && !fresh_q;
  assign dlast = dual_cur ? (dcnt_q == DUAL_LAST) :
                 (dcnt_q == SINGLE_LAST);
  assign dcnt_d = go_data ? 3'h0 :
                  !dphase_keep ? dcnt_q :
                  dlast ? 3'h0 : dcnt_q + 3'h1;
  // Natural roll-over of the counter gives the wrap to zero
  assign raddr_d = go_data ? addr_d[MEM_AW-1:0] :
                   (dphase_keep && dlast) ? raddr_q + 16'h0001 :
                   raddr_q; // RL11

  always_ff @(posedge sclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cyc_q <= CYC_NONE;
      op_q <= 8'h00;
      sdat_q <= 8'h00;
      addr_q <= 24'h00_0000;
      raddr_q <= 16'h0000;
      dcnt_q <= 3'h0;
      dphase_q <= 1'b0;
    end
    else
    begin
      cyc_q <= cyc_n;
      op_q <= op_cur;
      sdat_q <= sdat_d;
      addr_q <= addr_d;
      raddr_q <= raddr_d;
      dcnt_q <= dcnt_d;
      dphase_q <= go_data || dphase_keep;
    end
  end

  // Status byte into the serial domain; bits are quasi-static
  always_ff @(posedge sclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      stat_s1_q <= 8'h00;
      stat_s2_q <= 8'h00;
    end
    else
    begin
      stat_s1_q <= {wr_disable_q, STATUS_BIT6, bp_q, we_latch_q, busy_q};
      stat_s2_q <= stat_s1_q;
    end
  end

  // Output on the falling serial clock
  logic [7:0] out_byte;
  logic [3:0] out_sh;
  logic [7:0] out_shift;
  logic out_dual;

  // Status read repeats the live byte for as long as it is clocked
  assign out_byte = (op_q == OP_READ_STATUS) ? stat_s2_q :
                    mem_q[raddr_q]; // RL22
  assign out_dual = op_q == OP_DUAL_READ; // RL15
  assign out_sh = out_dual ? {dcnt_q, 1'b0} : {1'b0, dcnt_q};
  assign out_shift = 8'(out_byte << out_sh); // RL23

  always_ff @(negedge sclk_in or posedge cs_n_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      io1_out <= 1'b0;
      io1_oe_n_out <= 1'b1;
      io0_out <= 1'b0;
      io0_oe_n_out <= 1'b1;
    end
    else if (cs_n_in)
    begin
      io1_out <= 1'b0;
      io1_oe_n_out <= 1'b1;
      io0_out <= 1'b0;
      io0_oe_n_out <= 1'b1;
    end
    else
    begin
      io1_out <= out_shift[7]; // RL10
      io1_oe_n_out <= !dphase_keep;
      io0_out <= out_shift[6]; // RL14
      io0_oe_n_out <= !(dphase_keep && out_dual);
    end
  end

  // Core-side synchronisers
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      cs_s3_q <= 1'b1;
      wp_s1_q <= 1'b1;
      wp_s2_q <= 1'b1;
    end
    else
    begin
      cs_s1_q <= cs_n_in;
      cs_s2_q <= cs_s1_q;
      cs_s3_q <= cs_s2_q;
      wp_s1_q <= wp_n_in;
      wp_s2_q <= wp_s1_q;
    end
  end

  // Command decode at the end of a frame
  logic cs_rise;
  logic hw_protect;
  logic [3:0] sector;
  logic sect_prot;
  logic cmd_wr_enable;
  logic cmd_wstat;
  logic cmd_erase;
  logic tdone;
  logic mem_we;

  assign cs_rise = cs_s2_q && !cs_s3_q;
  // A pure level: order of bit and pin changes does not matter
  assign hw_protect = wr_disable_q && !wp_s2_q; // RL7 RL8
  assign sector = addr_q[MEM_AW-1:SECT_AW]; // RL16
  assign sect_prot = area_protected(bp_q, sector); // RL9
  assign cmd_wr_enable = cs_rise && !busy_q &&
                         op_q == OP_WRITE_ENABLE &&
                         cyc_q == CYC_OPCODE; // RL21
  assign cmd_wstat = cs_rise && !busy_q && op_q == OP_WRITE_STATUS &&
                     cyc_q == CYC_STATUS_DATA && // RL3
                     we_latch_q && !hw_protect; // RL5
  assign cmd_erase = cs_rise && !busy_q && op_q == OP_SECTOR_ERASE &&
                     cyc_q == CYC_ADDR && // RL17
                     we_latch_q && !sect_prot; // RL19
  assign tdone = timer_q == TIMER_ZERO;
  assign mem_we = state_q == ST_ERASE && !edone_q;

  always_comb
  begin
    state_d = state_q;
    timer_d = timer_q;
    case (state_q)
      ST_IDLE:
      begin
        if (cmd_wstat)
        begin
          state_d = ST_WSTAT; // RL4
          timer_d = 32'(WRITE_CYCLES - 1);
        end
        else if (cmd_erase)
        begin
          state_d = ST_ERASE; // RL18
          timer_d = 32'(SECTOR_ERASE_CYCLES - 1);
        end
      end
      ST_WSTAT, ST_ERASE:
      begin
        if (tdone)
          state_d = ST_IDLE;
        else
          timer_d = timer_q - 32'h0000_0001;
      end
      default:
        state_d = ST_IDLE;
    endcase
  end

  // Latch set by its command, cleared only when a timed cycle ends
  assign we_latch_d = cmd_wr_enable ? 1'b1 :
                      (state_q != ST_IDLE && tdone) ? 1'b0 :
                      we_latch_q; // RL1

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_q <= ST_IDLE;
      timer_q <= TIMER_ZERO;
      busy_q <= 1'b0;
      we_latch_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      timer_q <= timer_d;
      busy_q <= state_d != ST_IDLE; // RL4
      we_latch_q <= we_latch_d;
    end
  end

  // Written byte held until the timed cycle commits it
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      wdat_q <= 8'h00;
      wr_disable_q <= WR_DISABLE_RESET;
      bp_q <= BP_RESET;
    end
    else
    begin
      if (cmd_wstat)
        wdat_q <= sdat_q;
      if (state_q == ST_WSTAT && tdone)
      begin
        wr_disable_q <= wdat_q[ST_WR_DISABLE]; // RL2
        bp_q <= wdat_q[ST_BP_HI:ST_BP_LO]; // RL6
      end
    end
  end

  // Erase sweep: one byte per core cycle, well inside the erase time
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      esect_q <= 4'h0;
      ecnt_q <= 12'h000;
      edone_q <= 1'b0;
    end
    else if (cmd_erase)
    begin
      esect_q <= sector;
      ecnt_q <= 12'h000;
      edone_q <= 1'b0;
    end
    else if (mem_we)
    begin
      ecnt_q <= ecnt_q + 12'h001;
      edone_q <= ecnt_q == SECT_LAST;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (mem_we)
      mem_q[{esect_q, ecnt_q}] <= ERASED_BYTE; // RL16
  end

  // Checks
  a_wstat_end: assert property ( // RL4
    @(posedge clk_in) disable iff (!rst_n_in)
    (state_q == ST_WSTAT && tdone) |=>
      (!busy_q && !we_latch_q &&
       wr_disable_q == $past(wdat_q[ST_WR_DISABLE]) &&
       bp_q == $past(wdat_q[ST_BP_HI:ST_BP_LO])))
    else $error("status write did not commit and release");

  a_hwprot_refuse: assert property ( // RL5
    @(posedge clk_in) disable iff (!rst_n_in)
    (cs_rise && !busy_q && hw_protect && op_q == OP_WRITE_STATUS) |=>
      (state_q == ST_IDLE) ##1 $stable(bp_q) && $stable(wr_disable_q))
    else $error("status write accepted in hardware protected mode");

  a_latch_needed: assert property ( // RL1
    @(posedge clk_in) disable iff (!rst_n_in)
    (cs_rise && !busy_q && !we_latch_q) |=> !busy_q)
    else $error("timed cycle started without write enable");

  a_wstat_boundary: assert property ( // RL3
    @(posedge clk_in) disable iff (!rst_n_in)
    (cs_rise && !busy_q && op_q == OP_WRITE_STATUS &&
     cyc_q != CYC_STATUS_DATA) |=> !busy_q)
    else $error("status write taken off the byte boundary");

  a_soft_accept: assert property ( // RL6
    @(posedge clk_in) disable iff (!rst_n_in)
    (cs_rise && !busy_q && op_q == OP_WRITE_STATUS && we_latch_q &&
     cyc_q == CYC_STATUS_DATA && !(wr_disable_q && !wp_s2_q)) |=>
      busy_q [*2])
    else $error("status write refused in software protected mode");

  a_erase_protect: assert property ( // RL19
    @(posedge clk_in) disable iff (!rst_n_in)
    (cs_rise && !busy_q && op_q == OP_SECTOR_ERASE && sect_prot) |=>
      (!busy_q && we_latch_q == $past(we_latch_q)))
    else $error("erase of a protected sector started");

  a_erase_boundary: assert property ( // RL17
    @(posedge clk_in) disable iff (!rst_n_in)
    (cs_rise && !busy_q && op_q == OP_SECTOR_ERASE &&
     cyc_q != CYC_ADDR) |=> !busy_q)
    else $error("erase taken off the address boundary");

  a_erase_end: assert property ( // RL18
    @(posedge clk_in) disable iff (!rst_n_in)
    (state_q == ST_ERASE && tdone) |=>
      (!busy_q && !we_latch_q && edone_q))
    else $error("erase cycle ended badly");

  a_addr_wrap: assert property ( // RL11
    @(posedge sclk_in) disable iff (!rst_n_in || cs_n_in)
    (dphase_q && !fresh_q && dlast && raddr_q == RADDR_LAST) |=>
      raddr_q == 16'h0000)
    else $error("read address did not wrap to zero");

  a_fast_refused: assert property ( // RL13
    @(posedge sclk_in) disable iff (!rst_n_in || cs_n_in)
    (!fresh_q && cyc_q == CYC_FAST_DATA - 6'h01 &&
     op_q == OP_FAST_READ && busy_s) |=> !dphase_q)
    else $error("quick read served while busy");

  a_dual_refused: assert property ( // RL13
    @(posedge sclk_in) disable iff (!rst_n_in || cs_n_in)
    (!fresh_q && cyc_q == CYC_DUAL_DATA - 6'h01 &&
     op_q == OP_DUAL_READ && busy_s) |=> !dphase_q)
    else $error("dual read served while busy");

  a_io0_single: assert property ( // RL15
    @(posedge sclk_in) disable iff (!rst_n_in || cs_n_in)
    (!fresh_q && cyc_q > CYC_OPCODE && op_q != OP_DUAL_READ) |->
      io0_oe_n_out)
    else $error("second data pin driven outside dual read");

endmodule : flash_seq

/* File: verilog/flash_seq_pkg.sv */
// Purpose: Shared constants and types of the serial flash command logic.
// Assumes: Core clock of 20 MHz; mode 0 or 3 serial link.
// Notes: The array model is a small fixed window of the full address map.
package flash_seq_pkg;

  // Core clock
  localparam int CLK_PERIOD_NS = 50;

  // Self-timed cycle lengths
  localparam int STATUS_WRITE_TIME_NS = 5_000_000;
  localparam int FOUR_KIB_ERASE_TIME_NS = 40_000_000;
  localparam int STATUS_WRITE_CYCLES = STATUS_WRITE_TIME_NS / CLK_PERIOD_NS;
  localparam int ERASE_CYCLES = FOUR_KIB_ERASE_TIME_NS / CLK_PERIOD_NS;

  // Opcodes
  localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_READ_STATUS = 8'h05;
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_FAST_READ = 8'h0B;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] OP_DUAL_READ = 8'h3B;

  // Rising-edge counts inside a frame
  localparam logic [5:0] CYC_NONE = 6'h00;
  localparam logic [5:0] CYC_OPCODE = 6'h08;
  localparam logic [5:0] CYC_STATUS_DATA = 6'h10;
  localparam logic [5:0] CYC_DUAL_ADDR = 6'h14;
  localparam logic [5:0] CYC_DUAL_DATA = 6'h18;
  localparam logic [5:0] CYC_ADDR = 6'h20;
  localparam logic [5:0] CYC_FAST_DATA = 6'h28;
  localparam logic [5:0] CYC_MAX = 6'h3F;

  // Bit position inside a data byte
  localparam logic [2:0] SINGLE_LAST = 3'h7;
  localparam logic [2:0] DUAL_LAST = 3'h3;

  // Status byte layout
  localparam int ST_BUSY = 0;
  localparam int ST_WE_LATCH = 1;
  localparam int ST_BP_LO = 2;
  localparam int ST_BP_HI = 5;
  localparam int ST_WR_DISABLE = 7;
  localparam logic STATUS_BIT6 = 1'b0;
  localparam logic [3:0] BP_RESET = 4'h0;
  localparam logic WR_DISABLE_RESET = 1'b0;

  // Array model
  localparam int ADDR_W = 24;
  localparam int MEM_AW = 16;
  localparam int SECT_AW = 12;
  localparam int MEM_SIZE = 1 << MEM_AW;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [SECT_AW-1:0] SECT_LAST = 12'hFFF;
  localparam logic [MEM_AW-1:0] RADDR_LAST = 16'hFFFF;
  localparam logic [4:0] SECTOR_COUNT = 5'h10;
  localparam logic [3:0] BP_ALL = 4'h5;
  localparam logic [31:0] TIMER_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WSTAT = 2'b01,
    ST_ERASE = 2'b10
  } core_state_t;

  // Top sectors guarded by the protect level; five and above guard all
  function automatic logic area_protected(input logic [3:0] bp,
                                          input logic [3:0] sector);
    logic [4:0] span;
    begin
      if (bp == BP_RESET)
        span = 5'h00;
      else if (bp >= BP_ALL)
        span = SECTOR_COUNT;
      else
        span = 5'(5'h01 << (bp - 4'h1));
      area_protected = {1'b0, sector} >= 5'(SECTOR_COUNT - span);
    end
  endfunction : area_protected

  // Rising edge after which the first output bit is driven; none for others
  function automatic logic [5:0] data_start(input logic [7:0] op);
    begin
      case (op)
        OP_READ: data_start = CYC_ADDR;
        OP_FAST_READ: data_start = CYC_FAST_DATA;
        OP_DUAL_READ: data_start = CYC_DUAL_DATA;
        OP_READ_STATUS: data_start = CYC_OPCODE;
        default: data_start = CYC_NONE;
      endcase
    end
  endfunction : data_start

endpackage : flash_seq_pkg

/* File: verification/spi_host_model.sv */
// Purpose: Serial link host that frames commands and gathers read data.
// Assumes: Mode 0 link, 32 ns clock period, clock idle low between frames.
// Notes: Lines the host has released carry a toggling pattern, so a
//   missing device drive never reads back as a stale value.
`timescale 1ns/10ps
module spi_host_model (
  // Resolved link lines and device enables
  input wire logic io0_line_in,
  input wire logic io1_line_in,
  input wire logic io0_oe_n_in,
  input wire logic io1_oe_n_in,
  // Host drives
  output logic sclk_out,
  output logic cs_n_out,
  output logic io0_out,
  output logic io1_out
);
  logic [31:0] rx;
  logic seen0;
  logic seen1;
  event done;

  initial
  begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    io0_out = 1'b0;
    io1_out = 1'b1;
    seen0 = 1'b0;
    seen1 = 1'b0;
  end

  // Any device drive during a frame is remembered for the bench
  always @(negedge io0_oe_n_in) seen0 = 1'b1;
  always @(negedge io1_oe_n_in) seen1 = 1'b1;

  // n1 single edges, n2 dual edges, then nrx read edges
  task automatic frame(input logic [63:0] tx, input int n1, input int n2,
                       input int nrx, input bit drx);
    int p;
    begin
      p = 0;
      rx = 32'h0000_0000;
      seen0 = 1'b0;
      seen1 = 1'b0;
      cs_n_out = 1'b0;
      for (int i = 0; i < n1 + n2 + nrx; i++)
      begin
        if (i < n1)
        begin
          io0_out = tx[63-p];
          io1_out = ~io1_out;
          p = p + 1;
        end
        else if (i < n1 + n2)
        begin
          io1_out = tx[63-p];
          io0_out = tx[62-p];
          p = p + 2;
        end
        else
        begin
          io0_out = ~io0_out;
          io1_out = ~io1_out;
        end
        #16 sclk_out = 1'b1;
        if (i >= n1 + n2)
          rx = drx ? {rx[29:0], io1_line_in, io0_line_in} :
                     {rx[30:0], io1_line_in};
        #16 sclk_out = 1'b0;
      end
      // Select rises right after the last falling edge
      cs_n_out = 1'b1;
      if (nrx > 0)
        ->done;
    end
  endtask : frame
endmodule : spi_host_model

/* File: verification/serial_flash_status_read_erase_tb.sv */
// Purpose: Self-checking bench for the serial flash command logic.
// Assumes: Short self-timed cycles through the design parameters.
// Notes: Array content is only known after erase, so reads expect ones.
`timescale 1ns/10ps
module serial_flash_status_read_erase_tb;
  import flash_seq_pkg::*;
  localparam int WC = 200;
  localparam int EC = 4100;
  logic clk_in;
  logic rst_n_in;
  logic wp_n_in;
  logic sclk;
  logic cs_n;
  logic h_io0;
  logic h_io1;
  logic d_io0;
  logic d_io1;
  logic d_oe0_n;
  logic d_oe1_n;
  wire logic io0_line = d_oe0_n ? h_io0 : d_io0;
  wire logic io1_line = d_oe1_n ? h_io1 : d_io1;
  int fails = 0;
  int n_checks = 0;
  int cycles = 0;
  string nq[$];
  logic [33:0] eq[$];

  flash_seq #(.WRITE_CYCLES(WC), .SECTOR_ERASE_CYCLES(EC)) uut (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .wp_n_in(wp_n_in),
    .sclk_in(sclk), .cs_n_in(cs_n), .io0_in(io0_line),
    .io0_out(d_io0), .io0_oe_n_out(d_oe0_n), .io1_in(io1_line),
    .io1_out(d_io1), .io1_oe_n_out(d_oe1_n)
  );

  spi_host_model host (
    .io0_line_in(io0_line), .io1_line_in(io1_line),
    .io0_oe_n_in(d_oe0_n), .io1_oe_n_in(d_oe1_n),
    .sclk_out(sclk), .cs_n_out(cs_n), .io0_out(h_io0), .io1_out(h_io1)
  );

  initial
  begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end

  task automatic results();
    if (fails == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results

  // A hang is cut short well past the planned run length
  always @(posedge clk_in)
  begin
    cycles = cycles + 1;
    if (cycles == 30000)
    begin
      fails = fails + 1;
      results();
    end
  end

  task automatic check(input string name, input logic [33:0] seen,
                       input logic [33:0] exp);
    n_checks = n_checks + 1;
    if (seen !== exp)
    begin
      fails = fails + 1;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Top two bits: device drove io0, device drove io1
  always @(host.done)
  begin
    logic [33:0] e;
    logic [33:0] s;
    e = eq.pop_front();
    s = {host.seen0, host.seen1, e[32] ? host.rx : 32'h0000_0000};
    check(nq.pop_front(), s, e);
  end

  task automatic note(input string name, input logic [33:0] v);
    nq.push_back(name);
    eq.push_back(v);
  endtask : note

  task automatic gap(input int n);
    repeat (n) @(negedge clk_in);
  endtask : gap

  // Select stays high six core clocks between frames
  task automatic cmd(input logic [63:0] tx, input int n1, input int n2,
                     input int nrx, input bit drx);
    host.frame(tx, n1, n2, nrx, drx);
    gap(6);
  endtask : cmd

  task automatic wen();
    cmd({OP_WRITE_ENABLE, 56'h0}, 8, 0, 0, 1'b0);
  endtask : wen

  task automatic wstat(input logic [7:0] d, input int n);
    cmd({OP_WRITE_STATUS, d, 48'h0}, n, 0, 0, 1'b0);
  endtask : wstat

  task automatic erase(input logic [23:0] a, input int n);
    cmd({OP_SECTOR_ERASE, a, 32'h0}, n, 0, 0, 1'b0);
  endtask : erase

  task automatic status(input logic [7:0] v);
    note("status", {2'b01, 24'h00_0000, v});
    cmd({OP_READ_STATUS, 56'h0}, 8, 0, 8, 1'b0);
  endtask : status

  initial
  begin
    logic [3:0] bp;
    logic [23:0] a;
    rst_n_in = 1'b0;
    wp_n_in = 1'b1;
    void'($urandom(14746));
    repeat (3) @(negedge clk_in);
    rst_n_in = 1'b1;
    gap(2);
    status(8'h00);
    wstat(8'h3C, 16);
    status(8'h00);
    wen();
    note("status twice", {2'b01, 16'h0000, 16'h0202});
    cmd({OP_READ_STATUS, 56'h0}, 8, 0, 16, 1'b0);
    wstat(8'h3C, 15);
    status(8'h02);
    bp = 4'($urandom);
    wstat({2'b01, bp, 2'b11}, 16);
    status(8'h03);
    note("quick read busy", 34'h0);
    cmd({OP_FAST_READ, 56'h0}, 40, 0, 16, 1'b0);
    note("dual read busy", 34'h0);
    cmd({OP_DUAL_READ, 56'h0}, 8, 16, 8, 1'b1);
    gap(WC);
    status({2'b00, bp, 2'b00});
    // Pin low before the bit, then bit set before the pin drops
    for (int k = 0; k < 2; k++)
    begin
      wp_n_in = k[0];
      wen();
      wstat(8'h80, 16);
      gap(WC);
      wp_n_in = 1'b0;
      wen();
      wstat(8'h00, 16);
      status(8'h82);
      wp_n_in = 1'b1;
      gap(4);
      wstat(8'h00, 16);
      gap(WC);
      status(8'h00);
    end
    for (int k = 0; k < 2; k++)
    begin
      a = {8'h00, k[0] ? 4'h0 : 4'hF, 12'($urandom)};
      wen();
      erase(a, 32);
      status(8'h03);
      gap(EC);
      status(8'h00);
    end
    note("read", {2'b01, 16'h0000, 16'hFFFF});
    cmd({OP_READ, 24'h00_FFFF, 32'h0}, 32, 0, 16, 1'b0);
    note("quick read", {2'b01, 16'h0000, 16'hFFFF});
    cmd({OP_FAST_READ, 24'h00_0FFE, 32'h0}, 40, 0, 16, 1'b0);
    note("dual read", {2'b11, 16'h0000, 16'hFFFF});
    // Offset kept in the lower half so both bytes stay in sector zero
    cmd({OP_DUAL_READ, 13'h0000, 11'($urandom), 32'h0}, 8, 16, 8, 1'b1);
    wen();
    wstat(8'h04, 16);
    gap(WC);
    wen();
    erase(24'h00_F000, 32);
    status(8'h06);
    erase(24'h00_0123, 31);
    status(8'h06);
    erase(24'h00_0123, 32);
    status(8'h07);
    gap(EC);
    status(8'h04);
    gap(10);
    results();
  end
endmodule : serial_flash_status_read_erase_tb
